// ---- core/switch_global_power_control.v ----
// Contract
// RL1: Clock field picks host interface clock rate
// RL2: Host keeps serial clocks within chosen limit
// RL3: Restore bit enables fifth port preamble rebuild
// RL4: Tail tag bit inserts byte on port five
// RL5: Pass bit forwards flow control frames
// RL6: PLL power-down bit: one disables loop
// RL7: Mode field selects power operating state
// RL8: Soft power down needs write without readback
// RL9: Sleep after continuous no-energy delay elapsed
// RL10: Strap low at reset preloads energy mode
`timescale 1ns/1ps
`include "global_power_consts.vh"
module switch_global_power_control #(
  parameter UNIT_CYCLES = `SLEEP_UNIT_CYC
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire power_strap_in,
  input wire energy_detect_in,
  output reg [7:0] rdata_out,
  output reg [1:0] host_clk_sel_out,
  output reg preamble_restore_out,
  output reg tail_tag_out,
  output reg pass_flow_control_out,
  output reg pll_disable_out,
  output reg [1:0] power_mode_out,
  output reg soft_power_down_out,
  output reg low_power_out
);
  // ==========================================
  // Register state
  reg [1:0] mode_field;
  reg [7:0] sleep_delay;
  reg strap_taken;
  reg pd_armed;
  reg [31:0] unit_cnt;
  reg [7:0] unit_total;
  reg [31:0] next_unit_cnt;
  reg [7:0] next_unit_total;
  wire wr_gic = wr_in && (addr_in == `GIC_ADDR);
  wire wr_pmc = wr_in && (addr_in == `PMC_ADDR);
  wire wr_sdc = wr_in && (addr_in == `SDC_ADDR);
  wire rd_pmc = rd_in && (addr_in == `PMC_ADDR);
  wire sleep_reached;

  // ==========================================
  // Strap capture
  // Strap is caught on the first clock after release, not in reset,
  // so that the reset branch loads constants only
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  // ==========================================
  // Global interface control
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      host_clk_sel_out <= `GIC_CLKSEL_RST;
    end else if (wr_gic) begin
      // Reserved code 11 is stored as written and driven out unchanged on host_clk_sel_out
      host_clk_sel_out <= wdata_in[`GIC_CLKSEL_HI:`GIC_CLKSEL_LO]; // [RL1]
    end
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      preamble_restore_out <= `GIC_RESTORE_RST;
    end else if (wr_gic) begin
      preamble_restore_out <= wdata_in[`GIC_RESTORE]; // [RL3]
    end
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tail_tag_out <= 1'b0;
    end else if (wr_gic) begin
      tail_tag_out <= wdata_in[`GIC_TAILTAG]; // [RL4]
    end
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pass_flow_control_out <= 1'b0;
    end else if (wr_gic) begin
      pass_flow_control_out <= wdata_in[`GIC_PASSFC]; // [RL5]
    end
  end

  // ==========================================
  // Power management control
  // A mode field write landing on the strap edge loses to the strap; the PLL bit is still taken
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_field <= `MODE_NORMAL;
    end else if (!strap_taken) begin
      mode_field <= power_strap_in ? `MODE_NORMAL : `MODE_ENERGY; // [RL10]
    end else if (wr_pmc) begin
      mode_field <= wdata_in[`PMC_MODE_HI:`PMC_MODE_LO]; // [RL7]
    end
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pll_disable_out <= 1'b0;
    end else if (wr_pmc) begin
      pll_disable_out <= wdata_in[`PMC_PLLPD]; // [RL6]
    end
  end

  // ==========================================
  // Sleep delay
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sleep_delay <= `SDC_RST;
    end else if (wr_sdc) begin
      sleep_delay <= wdata_in; // [RL9]
    end
  end

  // ==========================================
  // Mode application
  // Soft power down arms on write and is cancelled by a readback
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pd_armed <= 1'b0;
      soft_power_down_out <= 1'b0;
      power_mode_out <= `MODE_NORMAL;
    end else begin
      power_mode_out <= mode_field; // [RL7]
      if (wr_pmc) begin
        pd_armed <= (wdata_in[`PMC_MODE_HI:`PMC_MODE_LO] == `MODE_SOFTPD); // [RL8]
      end else if (rd_pmc) begin
        pd_armed <= 1'b0; // [RL8]
      end
      soft_power_down_out <= pd_armed && !rd_pmc && (mode_field == `MODE_SOFTPD); // [RL8]
    end
  end

  // ==========================================
  // Energy-detect sleep timer
  always @* begin
    next_unit_cnt = unit_cnt;
    next_unit_total = unit_total;
    if (mode_field != `MODE_ENERGY || energy_detect_in) begin
      next_unit_cnt = 32'h0;
      next_unit_total = 8'h00;
    end else if (unit_total < sleep_delay) begin
      if (unit_cnt == UNIT_CYCLES - 1) begin
        next_unit_cnt = 32'h0;
        next_unit_total = unit_total + 8'h01; // [RL9]
      end else begin
        next_unit_cnt = unit_cnt + 32'h1;
      end
    end
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      unit_cnt <= 32'h0;
      unit_total <= 8'h00;
      low_power_out <= 1'b0;
    end else begin
      unit_cnt <= next_unit_cnt;
      unit_total <= next_unit_total;
      // Leaves low power on the next clock edge after energy returns
      low_power_out <= (mode_field == `MODE_ENERGY) && !energy_detect_in &&
                       sleep_reached; // [RL9]
    end
  end

  assign sleep_reached = (unit_total >= sleep_delay);

  // ==========================================
  // Register images for readback; reserved bits read as zero
  wire [7:0] gic_image;
  wire [7:0] pmc_image;
  assign gic_image = {2'h0, host_clk_sel_out, 1'b0, preamble_restore_out, tail_tag_out,
                      pass_flow_control_out};
  assign pmc_image = {2'h0, pll_disable_out, mode_field, 3'h0};

  // ==========================================
  // Read data, registered; unmapped reads return zero
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `GIC_ADDR: rdata_out <= gic_image;
        `FTB_ADDR: rdata_out <= `FTB_RST;
        `PMC_ADDR: rdata_out <= pmc_image;
        `SDC_ADDR: rdata_out <= sleep_delay;
        default: rdata_out <= 8'h00;
      endcase
    end
  end
endmodule // switch_global_power_control

// ---- core/global_power_consts.vh ----
`ifndef GLOBAL_POWER_CONSTS_VH
`define GLOBAL_POWER_CONSTS_VH
// ==========================================
// Register offsets
`define GIC_ADDR 8'h0c
`define FTB_ADDR 8'h0d
`define PMC_ADDR 8'h0e
`define SDC_ADDR 8'h0f
// ==========================================
// Field positions
`define GIC_CLKSEL_HI 5
`define GIC_CLKSEL_LO 4
`define GIC_RESTORE 2
`define GIC_TAILTAG 1
`define GIC_PASSFC 0
`define PMC_PLLPD 5
`define PMC_MODE_HI 4
`define PMC_MODE_LO 3
// ==========================================
// Reset values
`define GIC_CLKSEL_RST 2'h1
`define GIC_RESTORE_RST 1'h1
`define FTB_RST 8'h00
`define SDC_RST 8'h50
// ==========================================
// Codes
`define CLK_SLOW 2'h0
`define CLK_MID 2'h1
`define CLK_FAST 2'h2
`define MODE_NORMAL 2'h0
`define MODE_ENERGY 2'h1
`define MODE_SOFTPD 2'h2
`define MODE_SAVING 2'h3
// ==========================================
// Timing
`define CLK_HZ 25000000
`define SLEEP_UNIT_MS 20
`define SLEEP_UNIT_CYC ((`CLK_HZ / 1000) * `SLEEP_UNIT_MS)
`endif

// ---- test/switch_global_power_control_chk.sv ----
`timescale 1ns/1ps
`include "global_power_consts.vh"
module switch_global_power_control_chk (
  input wire clk_in, input wire arst_n_in, input wire [7:0] addr_in,
  input wire [7:0] wdata_in, input wire wr_in, input wire rd_in,
  input wire [7:0] rdata_out, input wire [1:0] host_clk_sel_out,
  input wire preamble_restore_out, input wire tail_tag_out,
  input wire pass_flow_control_out, input wire pll_disable_out,
  input wire [1:0] power_mode_out, input wire soft_power_down_out,
  input wire energy_detect_in, input wire low_power_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ==========================================
  // Register accesses and their effects
  sequence gic_wr; wr_in && addr_in == `GIC_ADDR; endsequence
  sequence pmc_wr; wr_in && addr_in == `PMC_ADDR; endsequence
  sequence pd_wr; pmc_wr ##0 wdata_in[4:3] == `MODE_SOFTPD; endsequence
  a_clk_sel: assert property (gic_wr |=> host_clk_sel_out == $past(wdata_in[5:4]))
    else $error("clock select not taken");
  a_restore_bit: assert property (gic_wr |=> preamble_restore_out == $past(wdata_in[2]))
    else $error("restore bit not taken");
  a_tail_bit: assert property (gic_wr |=> tail_tag_out == $past(wdata_in[1]))
    else $error("tail tag bit not taken");
  a_pass_bit: assert property (gic_wr |=> pass_flow_control_out == $past(wdata_in[0]))
    else $error("pass bit not taken");
  a_pll_sense: assert property (pmc_wr |=> pll_disable_out == $past(wdata_in[5]))
    else $error("pll control wrong sense");
  a_mode_apply: assert property (pmc_wr |=> ##1 power_mode_out == $past(wdata_in[4:3], 2))
    else $error("mode not applied");
  a_soft_pd_enter: assert property (pd_wr ##1 !rd_in && !wr_in |=> soft_power_down_out)
    else $error("soft power down not entered");
  a_soft_pd_cancel: assert property (rd_in && addr_in == `PMC_ADDR |=> !soft_power_down_out)
    else $error("read did not cancel soft power down");
  a_test_byte_ro: assert property (rd_in && addr_in == `FTB_ADDR |=> rdata_out == `FTB_RST)
    else $error("test byte not zero");
  a_sleep_gate: assert property (low_power_out |-> power_mode_out == `MODE_ENERGY && !$past(energy_detect_in))
    else $error("low power outside quiet energy mode");
endmodule // switch_global_power_control_chk
bind switch_global_power_control switch_global_power_control_chk chk_inst (.clk_in, .arst_n_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .host_clk_sel_out, .preamble_restore_out,
  .tail_tag_out, .pass_flow_control_out, .pll_disable_out, .power_mode_out, .soft_power_down_out,
  .energy_detect_in, .low_power_out);

// ---- test/switch_global_power_control_tb_top.sv ----
`timescale 1ns/1ps
module switch_global_power_control_tb_top;
  reg clk_in = 0, arst_n_in = 0, wr_in = 0, rd_in = 0, power_strap_in = 0, energy_detect_in = 1;
  reg [7:0] addr_in = 8'h00, wdata_in = 8'h00;
  wire [7:0] rdata_out;
  wire [1:0] host_clk_sel_out, power_mode_out;
  wire preamble_restore_out, tail_tag_out, pass_flow_control_out, pll_disable_out;
  wire soft_power_down_out, low_power_out;
  integer err_total = 0, tests_run = 0, gic = 8'h14, pmc = 8'h08, i, d;
  always #20 clk_in = ~clk_in;
  // Short sleep unit keeps the delay test quick
  switch_global_power_control #(.UNIT_CYCLES(4)) switch_global_power_control_inst (.clk_in,
    .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .power_strap_in, .energy_detect_in,
    .rdata_out, .host_clk_sel_out, .preamble_restore_out, .tail_tag_out, .pass_flow_control_out,
    .pll_disable_out, .power_mode_out, .soft_power_down_out, .low_power_out);
  // ==========================================
  // Helpers
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task acc(input w, input [7:0] a, input [7:0] dat);
    begin
      @(negedge clk_in);
      {wr_in, rd_in, addr_in, wdata_in} = {w, !w, a, dat};
      @(negedge clk_in);
      {wr_in, rd_in} = 2'h0;
      @(negedge clk_in);
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      acc(0, a, 8'h00);
      chk(rdata_out, e);
    end
  endtask
  task stop_test;
    begin
      $display("Checks %0d, errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #40000;
    err_total = err_total + 1;
    stop_test;
  end
  // ==========================================
  // Sequence
  initial begin
    d = $urandom(32'h358d8bf4);
    repeat (10) @(negedge clk_in);
    arst_n_in = 1;
    repeat (2) @(negedge clk_in);
    // Strobes come at most one every three core clocks, far inside the host serial clock limit
    rd(8'h0c, gic);
    rd(8'h0e, pmc);
    rd(8'h0f, 8'h50);
    acc(1, 8'h0d, 8'hff);
    rd(8'h0d, 8'h00);
    rd(8'h10, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      gic = ($urandom & 8'h07) | ((i % 3) << 4);
      acc(1, 8'h0c, gic);
      chk({host_clk_sel_out, preamble_restore_out, tail_tag_out, pass_flow_control_out},
        (gic >> 1) & 8'h18 | gic & 8'h07);
      rd(8'h0c, gic);
    end
    for (i = 3; i >= 0; i = i - 1) begin
      pmc = (i << 3) | ((i & 1) << 5);
      acc(1, 8'h0e, pmc);
      @(negedge clk_in);
      chk({pll_disable_out, power_mode_out, soft_power_down_out}, (pmc >> 2) | (i == 2));
      rd(8'h0e, pmc);
      chk(soft_power_down_out, 8'h00);
    end
    acc(1, 8'h0f, 8'h03);
    acc(1, 8'h0e, 8'h08);
    energy_detect_in = 0;
    repeat (10) @(negedge clk_in);
    chk(low_power_out, 8'h00);
    repeat (6) @(negedge clk_in);
    chk(low_power_out, 8'h01);
    // Second reset with the strap high: normal mode and no sleep
    arst_n_in = 0;
    power_strap_in = 1;
    repeat (2) @(negedge clk_in);
    arst_n_in = 1;
    repeat (2) @(negedge clk_in);
    chk(power_mode_out, 8'h00);
    rd(8'h0e, 8'h00);
    rd(8'h0f, 8'h50);
    chk(low_power_out, 8'h00);
    stop_test;
  end
endmodule // switch_global_power_control_tb_top
